//--- common/ucc_cfg_if.sv
// Interface carrying line configuration from the register file to the engines
`timescale 1ns/1ps
`default_nettype none
interface ucc_cfg_if;
    logic nine_bit;
    logic par_en;
    logic [1:0] par_type;
    logic two_rx_stop_count;
    logic run;
    logic [15:0] bit_clks;
    modport ctl (output nine_bit, par_en, par_type, two_rx_stop_count, run, bit_clks);
    modport eng (input nine_bit, par_en, par_type, two_rx_stop_count, run, bit_clks);
endinterface : ucc_cfg_if
`default_nettype wire

//--- common/ucc_pkg.sv
// Package with register map, field positions and state types of the UART control block
package ucc_pkg;
    // Register byte addresses (word aligned)
    localparam logic [3:0] ADDR_LINE_FMT = 4'h0;
    localparam logic [3:0] ADDR_DIR_IRQ = 4'h4;
    localparam logic [3:0] ADDR_SW_POL = 4'h8;
    localparam logic [3:0] ADDR_DATA = 4'hC;
    // line_format_control fields
    localparam int LF_MASTER_EN = 7;
    localparam int LF_WORD_LEN = 6;
    localparam int LF_PAR_EN = 5;
    localparam int LF_PAR_HI = 4;
    localparam int LF_PAR_LO = 3;
    localparam int LF_BREAK = 2;
    localparam int LF_RX9 = 1;
    localparam int LF_TX9 = 0;
    // direction_and_irq_control fields
    localparam int DI_TX_ON = 7;
    localparam int DI_RX_ON = 6;
    localparam int DI_RX_STOP_COUNT = 5;
    localparam int DI_ADDR = 4;
    localparam int DI_WAKE = 3;
    localparam int DI_RIE = 2;
    localparam int DI_TX_IDLE_IRQ_ENABLE = 1;
    localparam int DI_TX_EMPTY_IRQ_ENABLE = 0;
    // single_wire_polarity_control fields
    localparam int SP_TX_INV = 2;
    localparam int SP_RX_INV = 1;
    localparam int SP_SWM = 0;
    localparam logic [7:0] SP_MASK = 8'h07;
    // Reset values
    localparam logic [7:0] LF_RESET = 8'h00;
    localparam logic [7:0] DI_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'h00;
    // Parity types
    localparam logic [1:0] PAR_EVEN = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;
    // Break length in bit periods, transmitter stop bits
    localparam int BREAK_BITS = 13;
    localparam int TX_STOP_BITS = 2;
    // Default bit period in clocks
    localparam int BIT_CLKS_DEFAULT = 16;
    typedef enum logic [2:0] {
        UCC_TX_IDLE, UCC_TX_START, UCC_TX_DATA, UCC_TX_PAR, UCC_TX_STOP,
        UCC_TX_BRK
    } ucc_tx_state_e;
    typedef enum logic [2:0] {
        UCC_RX_IDLE, UCC_RX_START, UCC_RX_DATA, UCC_RX_PAR, UCC_RX_STOP
    } ucc_rx_state_e;
endpackage : ucc_pkg

//--- rtl/ucc_rx.sv
// Receive engine: samples mid bit, checks parity and stop bits
`timescale 1ns/1ps
`default_nettype none
module ucc_rx (
    input wire logic clk_in,
    input wire logic nrst_in,
    ucc_cfg_if.eng cfg,
    input wire logic line_in,
    output logic done_out,
    output logic [8:0] data_out,
    output logic perr_out,
    output logic ferr_out,
    output logic idle_out
);
    ucc_pkg::ucc_rx_state_e st_q;
    logic [15:0] cnt_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q;
    logic par_q;
    logic done_q;
    logic perr_q;
    logic ferr_q;
    wire mid = (cnt_q == {1'b0, cfg.bit_clks[15:1]});
    wire tick = (cnt_q == cfg.bit_clks - 16'h0001);
    wire [3:0] nbits = cfg.nine_bit ? 4'h9 : 4'h8;
    wire [3:0] nstops = cfg.two_rx_stop_count ? 4'h2 : 4'h1;
    wire exp_par = (cfg.par_type == ucc_pkg::PAR_EVEN) ? par_q :
                   (cfg.par_type == ucc_pkg::PAR_ODD) ? ~par_q :
                   (cfg.par_type == ucc_pkg::PAR_MARK);
    assign done_out = done_q;
    assign perr_out = perr_q;
    assign ferr_out = ferr_q;
    assign idle_out = (st_q == ucc_pkg::UCC_RX_IDLE);
    // Data right aligned, 8-bit words in the low byte
    assign data_out = cfg.nine_bit ? sh_q : {1'b0, sh_q[8:1]};
    ////////////////////////////////////////////////////////////////////////
    // Frame sampler; stop of run aborts reception
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !cfg.run) begin
            st_q <= ucc_pkg::UCC_RX_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
            sh_q <= 9'h000;
            par_q <= 1'b0;
            done_q <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            cnt_q <= (tick || st_q == ucc_pkg::UCC_RX_IDLE) ? 16'h0000 :
                     cnt_q + 16'h0001;
            case (st_q)
                ucc_pkg::UCC_RX_IDLE: begin
                    bit_q <= 4'h0;
                    par_q <= 1'b0;
                    ferr_q <= 1'b0;
                    if (!line_in)
                        st_q <= ucc_pkg::UCC_RX_START;
                end
                ucc_pkg::UCC_RX_START: begin
                    if (mid && line_in)
                        st_q <= ucc_pkg::UCC_RX_IDLE;
                    else if (tick)
                        st_q <= ucc_pkg::UCC_RX_DATA;
                end
                ucc_pkg::UCC_RX_DATA: begin
                    if (mid) begin
                        sh_q <= {line_in, sh_q[8:1]};
                        par_q <= par_q ^ line_in;
                    end
                    if (tick) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == nbits - 4'h1) begin
                            bit_q <= 4'h0;
                            st_q <= cfg.par_en ? ucc_pkg::UCC_RX_PAR :
                                    ucc_pkg::UCC_RX_STOP;
                        end
                    end
                end
                ucc_pkg::UCC_RX_PAR: begin
                    if (mid)
                        perr_q <= (line_in != exp_par);
                    if (tick)
                        st_q <= ucc_pkg::UCC_RX_STOP;
                end
                ucc_pkg::UCC_RX_STOP: begin
                    if (mid && !line_in)
                        ferr_q <= 1'b1;
                    if (tick) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == nstops - 4'h1) begin
                            st_q <= ucc_pkg::UCC_RX_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                end
                default: st_q <= ucc_pkg::UCC_RX_IDLE;
            endcase
            if (st_q == ucc_pkg::UCC_RX_IDLE && !line_in && !cfg.par_en)
                perr_q <= 1'b0;
        end
    end
endmodule : ucc_rx
`default_nettype wire

//--- rtl/ucc_top.sv
// UART control block: registers, pin steering, flags and interrupt request
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ucc_top #(
    parameter int BIT_CLKS = ucc_pkg::BIT_CLKS_DEFAULT
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic clock_stopped_in,
    input wire logic tx_pin_in,
    output logic tx_pin_out,
    output logic tx_pin_oe_n_out,
    input wire logic shared_pin_in,
    output logic shared_pin_out,
    output logic shared_pin_oe_n_out,
    output logic wake_req_out,
    output logic irq_out
);
    ucc_cfg_if cfg_tx ();
    ucc_cfg_if cfg_rx ();
    logic [7:0] lf_q;
    logic [7:0] di_q;
    logic [7:0] sp_q;
    logic [7:0] rd_q;
    logic ack_q;
    logic rx9_q;
    logic [7:0] rxd_q;
    logic [8:0] txd_q;
    logic tx_full_q;
    logic rx_ready_q;
    logic overrun_q;
    logic perr_q;
    logic ferr_q;
    logic addr_hit_q;
    logic wake_q;
    logic pin_prev_q;
    logic tx_busy;
    logic tx_line;
    logic rx_done;
    logic [8:0] rx_word;
    logic rx_perr;
    logic rx_ferr;
    logic rx_idle;
    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire master_on = lf_q[ucc_pkg::LF_MASTER_EN];
    wire tx_run = di_q[ucc_pkg::DI_TX_ON] && master_on;
    wire rx_run = di_q[ucc_pkg::DI_RX_ON] && master_on;
    wire single_line_select = sp_q[ucc_pkg::SP_SWM];
    wire req = (avs_read || avs_write) && !ack_q;
    wire wr = avs_write && !ack_q;
    wire wr_lf = wr && avs_address == ucc_pkg::ADDR_LINE_FMT;
    wire wr_di = wr && avs_address == ucc_pkg::ADDR_DIR_IRQ;
    wire wr_sp = wr && avs_address == ucc_pkg::ADDR_SW_POL;
    wire wr_data = wr && avs_address == ucc_pkg::ADDR_DATA;
    wire rd_data = avs_read && !ack_q && avs_address == ucc_pkg::ADDR_DATA;
    wire master_off = wr_lf && !avs_writedata[ucc_pkg::LF_MASTER_EN];
    wire nine = lf_q[ucc_pkg::LF_WORD_LEN];
    // Address bit: ninth bit in 9-bit format, data bit seven otherwise
    wire addr_bit = nine ? rx_word[8] : rx_word[7];
    wire keep = !di_q[ucc_pkg::DI_ADDR] || addr_bit;
    wire rx_take = rx_done && keep;
    wire tx_load = tx_full_q && !tx_busy && tx_run;
    wire tx_idle_flag = !tx_full_q && !tx_busy;
    wire tx_empty_flag = !tx_full_q;
    // Receive side: shared pin, optionally inverted
    wire rx_line = shared_pin_in ^ sp_q[ucc_pkg::SP_RX_INV];
    // Single-wire: shared pin transmits only if receiver is off
    wire tx_on_shared = single_line_select && tx_run && !rx_run;
    wire tx_level = tx_line ^ sp_q[ucc_pkg::SP_TX_INV];
    logic unused_pin;
    assign unused_pin = tx_pin_in;
    ////////////////////////////////////////////////////////////////////////
    // Configuration carried to the engines
    assign cfg_tx.nine_bit = nine;
    assign cfg_tx.par_en = lf_q[ucc_pkg::LF_PAR_EN];
    assign cfg_tx.par_type = lf_q[ucc_pkg::LF_PAR_HI:ucc_pkg::LF_PAR_LO];
    assign cfg_tx.two_rx_stop_count = 1'b1;
    assign cfg_tx.run = tx_run;
    assign cfg_tx.bit_clks = 16'(BIT_CLKS);
    assign cfg_rx.nine_bit = nine;
    assign cfg_rx.par_en = lf_q[ucc_pkg::LF_PAR_EN];
    assign cfg_rx.par_type = lf_q[ucc_pkg::LF_PAR_HI:ucc_pkg::LF_PAR_LO];
    assign cfg_rx.two_rx_stop_count = di_q[ucc_pkg::DI_RX_STOP_COUNT];
    assign cfg_rx.run = rx_run;
    assign cfg_rx.bit_clks = 16'(BIT_CLKS);
    ////////////////////////////////////////////////////////////////////////
    // Engines
    ucc_tx u_tx (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .cfg(cfg_tx),
        .load_in(tx_load),
        .data_in(txd_q),
        .brk_in(lf_q[ucc_pkg::LF_BREAK]),
        .busy_out(tx_busy),
        .line_out(tx_line)
    );
    ucc_rx u_rx (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .cfg(cfg_rx),
        .line_in(rx_line),
        .done_out(rx_done),
        .data_out(rx_word),
        .perr_out(rx_perr),
        .ferr_out(rx_ferr),
        .idle_out(rx_idle)
    );
    ////////////////////////////////////////////////////////////////////////
    // Pins: low enable means driven; floating when off
    assign tx_pin_out = tx_level;
    assign tx_pin_oe_n_out = !(tx_run && !single_line_select);
    assign shared_pin_out = tx_level;
    assign shared_pin_oe_n_out = !tx_on_shared;
    assign wake_req_out = wake_q;
    // Interrupt request, OR of enabled sources
    assign irq_out = (di_q[ucc_pkg::DI_RIE] && (rx_ready_q || overrun_q))
        || (di_q[ucc_pkg::DI_TX_IDLE_IRQ_ENABLE] && tx_idle_flag)
        || (di_q[ucc_pkg::DI_TX_EMPTY_IRQ_ENABLE] && tx_empty_flag)
        || (di_q[ucc_pkg::DI_ADDR] && addr_hit_q)
        || wake_q;
    // Avalon answer: one wait cycle, then ack
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = {24'h000000, rd_q};
    ////////////////////////////////////////////////////////////////////////
    // Bus handshake and read data
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ack_q <= 1'b0;
            rd_q <= 8'h00;
        end else begin
            ack_q <= req;
            if (avs_read && !ack_q) begin
                case (avs_address)
                    ucc_pkg::ADDR_LINE_FMT: rd_q <= {lf_q[7:2], rx9_q, 1'b0};
                    ucc_pkg::ADDR_DIR_IRQ: rd_q <= di_q;
                    ucc_pkg::ADDR_SW_POL: rd_q <= sp_q & ucc_pkg::SP_MASK;
                    ucc_pkg::ADDR_DATA: rd_q <= rxd_q;
                    default: rd_q <= 8'h00;
                endcase
            end
        end
    end
    // Control registers; master off clears transmitter and receiver enables and break
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            lf_q <= ucc_pkg::LF_RESET;
            di_q <= ucc_pkg::DI_RESET;
            sp_q <= ucc_pkg::SP_RESET;
        end else begin
            if (wr_lf) begin
                lf_q <= avs_writedata[7:0];
                if (master_off)
                    lf_q[ucc_pkg::LF_BREAK] <= 1'b0;
            end
            if (wr_di)
                di_q <= avs_writedata[7:0];
            if (master_off || !master_on) begin
                di_q[ucc_pkg::DI_TX_ON] <= 1'b0;
                di_q[ucc_pkg::DI_RX_ON] <= 1'b0;
            end
            if (wr_sp)
                sp_q <= avs_writedata[7:0] & ucc_pkg::SP_MASK;
        end
    end
    // Transmit holding word with ninth bit
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !tx_run) begin
            txd_q <= 9'h000;
            tx_full_q <= 1'b0;
        end else if (wr_data) begin
            txd_q <= {lf_q[ucc_pkg::LF_TX9] && nine, avs_writedata[7:0]};
            tx_full_q <= 1'b1;
        end else if (tx_load) begin
            tx_full_q <= 1'b0;
        end
    end
    // Receive flags; an arriving word wins over a read clear
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !rx_run) begin
            rx_ready_q <= 1'b0;
            overrun_q <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            addr_hit_q <= 1'b0;
            rxd_q <= 8'h00;
            rx9_q <= 1'b0;
        end else if (rx_take) begin
            rx_ready_q <= 1'b1;
            overrun_q <= overrun_q || (rx_ready_q && !rd_data);
            rxd_q <= rx_word[7:0];
            rx9_q <= nine && rx_word[8];
            perr_q <= rx_perr;
            ferr_q <= rx_ferr;
            addr_hit_q <= di_q[ucc_pkg::DI_ADDR];
        end else if (rd_data) begin
            rx_ready_q <= 1'b0;
            overrun_q <= 1'b0;
            addr_hit_q <= 1'b0;
        end
    end
    // Wake request only while core clock is stopped
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pin_prev_q <= 1'b1;
            wake_q <= 1'b0;
        end else begin
            pin_prev_q <= rx_line;
            if (clock_stopped_in && di_q[ucc_pkg::DI_WAKE] && pin_prev_q
                && !rx_line)
                wake_q <= 1'b1;
            else if (!clock_stopped_in)
                wake_q <= 1'b0;
        end
    end
    logic unused_st;
    assign unused_st = rx_idle ^ perr_q ^ ferr_q;
endmodule : ucc_top
`default_nettype wire

//--- rtl/ucc_tx.sv
// Transmit engine: start, data, parity, two stop bits and break
`timescale 1ns/1ps
`default_nettype none
module ucc_tx (
    input wire logic clk_in,
    input wire logic nrst_in,
    ucc_cfg_if.eng cfg,
    input wire logic load_in,
    input wire logic [8:0] data_in,
    input wire logic brk_in,
    output logic busy_out,
    output logic line_out
);
    ucc_pkg::ucc_tx_state_e st_q;
    logic [15:0] cnt_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q;
    logic par_q;
    logic line_q;
    wire tick = (cnt_q == cfg.bit_clks - 16'h0001);
    wire [3:0] nbits = cfg.nine_bit ? 4'h9 : 4'h8;
    wire par_bit = (cfg.par_type == ucc_pkg::PAR_EVEN) ? par_q :
                   (cfg.par_type == ucc_pkg::PAR_ODD) ? ~par_q :
                   (cfg.par_type == ucc_pkg::PAR_MARK);
    assign busy_out = (st_q != ucc_pkg::UCC_TX_IDLE);
    assign line_out = line_q;
    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer; stop of run aborts at once
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !cfg.run) begin
            st_q <= ucc_pkg::UCC_TX_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
            sh_q <= 9'h000;
            par_q <= 1'b0;
            line_q <= 1'b1;
        end else begin
            cnt_q <= (tick || st_q == ucc_pkg::UCC_TX_IDLE) ? 16'h0000 :
                     cnt_q + 16'h0001;
            case (st_q)
                ucc_pkg::UCC_TX_IDLE: begin
                    bit_q <= 4'h0;
                    if (load_in) begin
                        st_q <= ucc_pkg::UCC_TX_START;
                        sh_q <= data_in;
                        par_q <= 1'b0;
                        line_q <= 1'b0;
                    end else if (brk_in) begin
                        st_q <= ucc_pkg::UCC_TX_BRK;
                        line_q <= 1'b0;
                    end else begin
                        line_q <= 1'b1;
                    end
                end
                ucc_pkg::UCC_TX_START: if (tick) begin
                    st_q <= ucc_pkg::UCC_TX_DATA;
                    line_q <= sh_q[0];
                end
                ucc_pkg::UCC_TX_DATA: if (tick) begin
                    par_q <= par_q ^ sh_q[0];
                    sh_q <= {1'b0, sh_q[8:1]};
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == nbits - 4'h1) begin
                        bit_q <= 4'h0;
                        st_q <= cfg.par_en ? ucc_pkg::UCC_TX_PAR :
                                ucc_pkg::UCC_TX_STOP;
                        line_q <= cfg.par_en ?
                            ((cfg.par_type == ucc_pkg::PAR_EVEN) ?
                                (par_q ^ sh_q[0]) :
                             (cfg.par_type == ucc_pkg::PAR_ODD) ?
                                ~(par_q ^ sh_q[0]) :
                             (cfg.par_type == ucc_pkg::PAR_MARK)) : 1'b1;
                    end else begin
                        line_q <= sh_q[1];
                    end
                end
                ucc_pkg::UCC_TX_PAR: if (tick) begin
                    st_q <= ucc_pkg::UCC_TX_STOP;
                    line_q <= 1'b1;
                end
                ucc_pkg::UCC_TX_STOP: if (tick) begin
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == 4'(ucc_pkg::TX_STOP_BITS - 1))
                        st_q <= ucc_pkg::UCC_TX_IDLE;
                end
                ucc_pkg::UCC_TX_BRK: begin
                    line_q <= 1'b0;
                    if (tick && bit_q != 4'(ucc_pkg::BREAK_BITS))
                        bit_q <= bit_q + 4'h1;
                    if (!brk_in && bit_q == 4'(ucc_pkg::BREAK_BITS)) begin
                        st_q <= ucc_pkg::UCC_TX_IDLE;
                        line_q <= 1'b1;
                    end
                end
                default: st_q <= ucc_pkg::UCC_TX_IDLE;
            endcase
        end
    end
    logic unused_par;
    assign unused_par = par_bit;
endmodule : ucc_tx
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the UART control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int B = 4;
    localparam logic [7:0] D = 8'h0B;
    typedef struct packed {logic [3:0] wa; logic [7:0] wd; logic [3:0] ra;
        logic [7:0] re; logic irq; logic [1:0] oe;} ucc_row_s;
    localparam ucc_row_s ROWS [10] = '{'{4'h8, 8'hFF, 4'h8, 8'h07, 0, 3},
        '{4'h8, 8'h00, 4'h8, 8'h00, 0, 3}, '{4'h0, 8'h80, 4'h0, 8'h80, 0, 3},
        '{4'h4, 8'h81, 4'h4, 8'h81, 1, 1}, '{4'h4, 8'h82, 4'h4, 8'h82, 1, 1},
        '{4'h4, 8'hC4, 4'h4, 8'hC4, 0, 1}, '{4'h8, 8'h01, 4'h8, 8'h01, 0, 3},
        '{4'h4, 8'h84, 4'h4, 8'h84, 0, 2}, '{4'h0, 8'h00, 4'h4, 8'h04, 0, 3},
        '{4'h2, 8'h55, 4'h2, 8'h00, 0, 3}};
    logic clk_in = 1'b0, nrst_in = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q;
    logic clock_stopped_in = 1'b0, avs_waitrequest, tx_pin_out, far_line;
    logic tx_pin_oe_n_out, shared_pin_out, shared_pin_oe_n_out, wake_req_out;
    logic irq_out;
    int miscompares = 0, checked = 0;
    wire tx_wire = tx_pin_oe_n_out ? ~tx_pin_out : tx_pin_out;
    wire sh_wire = shared_pin_oe_n_out ? far_line : shared_pin_out;
    always #2.5 clk_in = ~clk_in;
    ucc_top #(.BIT_CLKS(B)) ucc_top_i (.clk_in, .nrst_in, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .clock_stopped_in, .tx_pin_in(tx_wire), .tx_pin_out, .tx_pin_oe_n_out,
        .shared_pin_in(sh_wire), .shared_pin_out, .shared_pin_oe_n_out,
        .wake_req_out, .irq_out);
    ucc_remote #(.BIT_CLKS(B)) ucc_remote_i (.clk_in, .line_in(tx_wire),
        .line_out(far_line));
    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {avs_address, avs_write, avs_read} <= {a, wr, !wr};
        avs_writedata <= {24'h0, d};
        @(posedge clk_in);
        while (avs_waitrequest !== 1'b0) @(posedge clk_in);
        rd_q = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
    endtask : bus
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    // Watchdog
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        foreach (ROWS[i]) begin
            bus(1'b1, ROWS[i].wa, ROWS[i].wd);
            bus(1'b0, ROWS[i].ra, 8'h00);
            check(rd_q, ROWS[i].re);
            check(irq_out, ROWS[i].irq);
            check({tx_pin_oe_n_out, shared_pin_oe_n_out}, ROWS[i].oe);
        end
        bus(1'b1, 4'h8, 8'h00);
        bus(1'b1, 4'h0, 8'hA0);
        bus(1'b1, 4'h4, 8'h80);
        for (int p = 0; p < 5; p++) begin
            bus(1'b1, 4'h0, p < 4 ? 8'hA0 | 8'(p << 3) : 8'hC1);
            bus(1'b1, 4'hC, D);
            repeat (14 * B) @(posedge clk_in);
            check(ucc_remote_i.got_q, {2'h3, (p == 0) ? ^D : (p == 1) ? ~^D :
                (p != 3), D});
        end
        bus(1'b1, 4'h0, 8'h84);
        repeat (13 * B) @(posedge clk_in);
        check(tx_pin_out, 1'b0);
        bus(1'b1, 4'h0, 8'h80);
        repeat (2 * B) @(posedge clk_in);
        check(tx_pin_out, 1'b1);
        bus(1'b1, 4'h8, 8'h04);
        check(tx_pin_out, 1'b0);
        check(shared_pin_out, 1'b0);
        bus(1'b1, 4'h8, 8'h00);
        bus(1'b1, 4'hC, 8'h00);
        bus(1'b1, 4'h4, 8'h54);
        check(tx_pin_oe_n_out, 1'b1);
        ucc_remote_i.put({3'h7, 8'h12});
        check(irq_out, 1'b0);
        ucc_remote_i.put({3'h7, 8'h93});
        check(irq_out, 1'b1);
        bus(1'b0, 4'hC, 8'h00);
        check(rd_q, 32'h93);
        bus(1'b1, 4'h0, 8'hC0);
        bus(1'b1, 4'h4, 8'h40);
        ucc_remote_i.put({2'h3, 1'b1, 8'h3C});
        bus(1'b0, 4'h0, 8'h00);
        check(rd_q & 32'h2, 32'h2);
        clock_stopped_in <= 1'b1;
        ucc_remote_i.put({3'h7, 8'h00});
        check(wake_req_out, 1'b0);
        bus(1'b1, 4'h4, 8'h48);
        ucc_remote_i.put({3'h7, 8'h00});
        check(wake_req_out, 1'b1);
        clock_stopped_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check(wake_req_out, 1'b0);
        nrst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int a = 0; a < 3; a++) begin
            bus(1'b0, 4'(a * 4), 8'h00);
            check(rd_q, 32'h0);
        end
        summarize();
    end
endmodule : testbench
bind ucc_top ucc_properties #(.BIT_CLKS(BIT_CLKS)) ucc_properties_i (.clk_in,
    .nrst_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .clock_stopped_in, .tx_pin_out,
    .tx_pin_oe_n_out, .shared_pin_oe_n_out, .wake_req_out, .irq_out);
`default_nettype wire

//--- tb/ucc_properties.sv
// Checker with port-level properties of the UART control block
`timescale 1ns/1ps
`default_nettype none
module ucc_properties #(parameter int BIT_CLKS = 4) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic clock_stopped_in,
    input wire logic tx_pin_out,
    input wire logic tx_pin_oe_n_out,
    input wire logic shared_pin_oe_n_out,
    input wire logic wake_req_out,
    input wire logic irq_out
);
    localparam int DATA_MAX = 11 * BIT_CLKS;
    localparam int BRK_MIN = 13 * BIT_CLKS;
    logic [7:0] lf_q, di_q, sp_q;
    logic [15:0] low_q;
    wire take = avs_write && avs_waitrequest;
    wire tx_en = lf_q[7] && di_q[7];
    wire line = tx_pin_out ^ sp_q[2];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////////
    // Shadow of the control registers, taken at the accept edge
    always_ff @(posedge clk_in) begin
        if (!nrst_in) {lf_q, di_q, sp_q} <= 24'h0;
        else if (take && avs_address == 4'h0) begin
            lf_q <= avs_writedata[7:0];
            if (!avs_writedata[7]) di_q[7:6] <= 2'h0;
        end
        else if (take && avs_address == 4'h4)
            di_q <= avs_writedata[7:0] & {{2{lf_q[7]}}, 6'h3F};
        else if (take && avs_address == 4'h8) sp_q <= avs_writedata[7:0];
    end
    // Length of the present low run on the transmit line
    always_ff @(posedge clk_in) begin
        if (!nrst_in || line || !tx_en) low_q <= 16'h0;
        else if (low_q != 16'hFFFF) low_q <= low_q + 16'h1;
    end
    sequence clk_running; !clock_stopped_in [*2]; endsequence
    ////////////////////////////////////////////////////////////////////
    chk_tx_gate: assert property (
        tx_pin_oe_n_out == !(tx_en && !sp_q[0])) else $error("tx drive bad");
    chk_shared_gate: assert property (
        shared_pin_oe_n_out == !(lf_q[7] && sp_q[0] && di_q[7:6] == 2'h2))
        else $error("shared pin drive bad");
    chk_wait_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest) else $error("no bus answer");
    chk_read_blank: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:8] == 24'h0 && (avs_address[1:0] == 2'h0 ||
        avs_readdata[7:0] == 8'h0)) else $error("unmapped read not zero");
    chk_irq_quiet: assert property (
        di_q[4:0] == 5'h0 && !wake_req_out |-> !irq_out) else $error("irq");
    chk_wake_running: assert property (clk_running |-> !wake_req_out)
        else $error("wake while clock runs");
    chk_break_min: assert property (tx_en && line && low_q != 16'h0 |->
        low_q <= DATA_MAX || low_q >= BRK_MIN) else $error("short break");
    chk_break_hold: assert property (tx_en && lf_q[2] &&
        low_q > DATA_MAX |-> !line) else $error("break released early");
endmodule : ucc_properties
`default_nettype wire

//--- tb/ucc_remote.sv
// Remote serial partner: sends frames and captures received frames
`timescale 1ns/1ps
`default_nettype none
module ucc_remote #(parameter int BIT_CLKS = 4) (
    input wire logic clk_in,
    input wire logic line_in,
    output logic line_out
);
    logic [10:0] got_q;
    initial line_out = 1'b1;
    // Start bit then eleven bits, least significant first
    task automatic put(input logic [10:0] f);
        @(posedge clk_in) line_out <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk_in);
        for (int i = 0; i < 11; i++) begin
            line_out <= f[i];
            repeat (BIT_CLKS) @(posedge clk_in);
        end
        line_out <= 1'b1;
    endtask : put
    // Sample eleven bits mid period after each start edge
    initial begin
        got_q = 11'h0;
        forever begin
            @(negedge line_in);
            repeat (BIT_CLKS / 2) @(posedge clk_in);
            for (int j = 0; j < 11; j++) begin
                repeat (BIT_CLKS) @(posedge clk_in);
                got_q[j] = line_in;
            end
        end
    end
endmodule : ucc_remote
`default_nettype wire
